//--- shared/osc_consts.vh
// oscillator source control: register offsets, fields, reset values, timing
// assumes plain port register access, 8-bit data, 100 MHz clk_sys
`ifndef OSC_CONSTS_VH
`define OSC_CONSTS_VH

`define OSC_ADDR_W          4
`define OSC_OFS_SYSCLK_SEL  4'h0
`define OSC_OFS_PREC_CTRL   4'h1
`define OSC_OFS_PREC_TRIM   4'h2
`define OSC_OFS_EXT_CFG     4'h3
`define OSC_OFS_STATUS      4'h4

`define OSC_SEL_PREC        3'h0
`define OSC_SEL_EXT         3'h1
`define OSC_SEL_LP_DIV8     3'h2
`define OSC_SEL_RTC         3'h3
`define OSC_SEL_LP          3'h4
`define OSC_SEL_RST         3'h4

`define OSC_PREC_EN_BIT     7
`define OSC_PREC_RDY_BIT    6
`define OSC_PREC_CTRL_RST   8'h00
`define OSC_SPREAD_BIT      7
`define OSC_TRIM_RST        7'h40

`define OSC_EXT_EN_BIT      7
`define OSC_EXT_DIV2_BIT    6
`define OSC_EXT_MODE_HI     5
`define OSC_EXT_MODE_LO     4
`define OSC_EXT_DRV_HI      2
`define OSC_EXT_DRV_LO      0
`define OSC_EXT_CFG_RST     8'h00
`define OSC_MODE_CMOS       2'h0
`define OSC_MODE_XTAL       2'h1
`define OSC_MODE_RC         2'h2
`define OSC_MODE_CAP        2'h3

`define OSC_VALID_BIT       7

`define OSC_SS_DIV          16'h0180
`define OSC_SS_STEPS        3'h6
`define OSC_SS_HALF_TICKS   16'h0020
`define OSC_SS_STEP_LAST    9'h01F
`define OSC_SETTLE_EDGES    16'h0100
`define OSC_PREC_START      16'h0040
`define OSC_SWITCH_EDGES    16'h0002

`endif

//--- design/osc_edge_counter.v
// saturating edge counter for one oscillator tap
// assumes osc_in already synchronised into clk_sys
`timescale 1ns/1ps
module osc_edge_counter (
  clk_sys,
  rst_b,
  clear,
  osc_in,
  limit,
  done
);
  input             clk_sys;
  input             rst_b;
  input             clear;
  input             osc_in;
  input      [15:0] limit;
  output            done;

  reg        [15:0] count_ff;
  reg               prev_ff;
  wire              rise;

  assign rise = osc_in & ~prev_ff;
  assign done = (count_ff >= limit);

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= 16'h0000;
      prev_ff  <= 1'b0;
    end else begin
      prev_ff <= osc_in;
      if (clear) begin
        count_ff <= 16'h0000;
      end else if (rise && !done) begin
        count_ff <= count_ff + 16'h0001;
      end
    end
  end
endmodule // osc_edge_counter

//--- design/osc_source_ctrl.v
// oscillator source control: select, spread, low power enable, ext osc
// assumes oscillator taps are sampled views of analog clocks, slow vs clk_sys
`timescale 1ns/1ps
`include "osc_consts.vh"
module osc_source_ctrl (
  clk_sys,
  rst_b,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  prec_osc_clk,
  lp_osc_clk,
  rtc_osc_clk,
  ext_osc_pin_a_in,
  ext_osc_pin_b_in,
  ext_osc_pin_a_out,
  ext_osc_pin_a_oe_b,
  ext_osc_pin_b_out,
  ext_osc_pin_b_oe_b,
  prec_osc_en,
  prec_osc_trim,
  prec_osc_ss_step,
  lp_osc_en,
  ext_osc_en,
  ext_osc_mode,
  ext_osc_drive_level,
  sysclk_src,
  ext_periph_clk,
  sysclk_undiv
);
  input                   clk_sys;
  input                   rst_b;
  input  [`OSC_ADDR_W-1:0] reg_addr;
  input             [7:0] reg_wdata;
  input                   reg_wr;
  input                   reg_rd;
  output            [7:0] reg_rdata;
  input                   prec_osc_clk;
  input                   lp_osc_clk;
  input                   rtc_osc_clk;
  input                   ext_osc_pin_a_in;
  input                   ext_osc_pin_b_in;
  output                  ext_osc_pin_a_out;
  output                  ext_osc_pin_a_oe_b;
  output                  ext_osc_pin_b_out;
  output                  ext_osc_pin_b_oe_b;
  output                  prec_osc_en;
  output            [6:0] prec_osc_trim;
  output            [2:0] prec_osc_ss_step;
  output                  lp_osc_en;
  output                  ext_osc_en;
  output            [1:0] ext_osc_mode;
  output            [2:0] ext_osc_drive_level;
  output            [2:0] sysclk_src;
  output                  ext_periph_clk;
  output                  sysclk_undiv;

  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_SETTLE = 3'b010;
  localparam [2:0] ST_VALID  = 3'b100;

  reg  [7:0] reg_rdata_ff;
  reg  [2:0] sel_req_ff;
  reg  [2:0] sel_act_ff;
  reg        prec_en_ff;
  reg        spread_ff;
  reg  [6:0] trim_ff;
  reg  [7:0] ext_cfg_ff;
  reg  [2:0] xst_ff;
  reg  [2:0] nxt_xst;
  reg  [1:0] sync_prec_ff, sync_lp_ff, sync_rtc_ff, sync_xa_ff, sync_xb_ff;
  reg        ext_div_ff;
  reg        xb_prev_ff;
  reg  [8:0] ss_cnt_ff;
  reg  [2:0] ss_step_ff;
  reg        ss_down_ff;
  reg        lp_div_prev_ff;
  reg        prec_prev_ff;
  reg  [2:0] lp_div_ff;
  reg        sw_pend_ff;
  reg  [7:0] nxt_rdata;

  wire       prec_s = sync_prec_ff[1];
  wire       lp_s   = sync_lp_ff[1];
  wire       rtc_s  = sync_rtc_ff[1];
  wire       xb_s   = sync_xb_ff[1];
  wire       ext_en = ext_cfg_ff[`OSC_EXT_EN_BIT];
  wire [1:0] mode   = ext_cfg_ff[`OSC_EXT_MODE_HI:`OSC_EXT_MODE_LO];
  wire       is_cmos = (mode == `OSC_MODE_CMOS);
  wire       wr_ext = reg_wr && (reg_addr == `OSC_OFS_EXT_CFG);
  wire       settle_done, prec_done;
  wire       xb_rise = xb_s & ~xb_prev_ff;
  wire       ext_clk = ext_cfg_ff[`OSC_EXT_DIV2_BIT] ? ext_div_ff : xb_s;
  wire       lp_div8 = lp_div_ff[2];
  wire       sel_ok  = (reg_wdata[2:0] <= `OSC_SEL_LP);
  wire       old_slow, new_slow;
  reg        old_clk, new_clk;

  // first stage only feeds second stage
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_prec_ff <= 2'b00;
      sync_lp_ff   <= 2'b00;
      sync_rtc_ff  <= 2'b00;
      sync_xa_ff   <= 2'b00;
      sync_xb_ff   <= 2'b00;
    end else begin
      sync_prec_ff <= {sync_prec_ff[0], prec_osc_clk};
      sync_lp_ff   <= {sync_lp_ff[0], lp_osc_clk};
      sync_rtc_ff  <= {sync_rtc_ff[0], rtc_osc_clk};
      sync_xa_ff   <= {sync_xa_ff[0], ext_osc_pin_a_in};
      sync_xb_ff   <= {sync_xb_ff[0], ext_osc_pin_b_in};
    end
  end

  // register file
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sel_req_ff <= `OSC_SEL_RST;
      prec_en_ff <= 1'b0;
      spread_ff  <= 1'b0;
      trim_ff    <= `OSC_TRIM_RST;
      ext_cfg_ff <= `OSC_EXT_CFG_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `OSC_OFS_SYSCLK_SEL: begin
          if (sel_ok) begin
            sel_req_ff <= reg_wdata[2:0];
          end
        end
        `OSC_OFS_PREC_CTRL: prec_en_ff <= reg_wdata[`OSC_PREC_EN_BIT];
        `OSC_OFS_PREC_TRIM: begin
          spread_ff <= reg_wdata[`OSC_SPREAD_BIT];
          trim_ff   <= reg_wdata[6:0];
        end
        `OSC_OFS_EXT_CFG:   ext_cfg_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data one cycle later, unmapped reads zero
  always @* begin
    case (reg_addr)
      `OSC_OFS_SYSCLK_SEL: nxt_rdata = {5'h00, sel_act_ff};
      `OSC_OFS_PREC_CTRL:  nxt_rdata = {prec_en_ff, prec_done, 6'h00};
      `OSC_OFS_PREC_TRIM:  nxt_rdata = {spread_ff, trim_ff};
      `OSC_OFS_EXT_CFG:    nxt_rdata = ext_cfg_ff;
      `OSC_OFS_STATUS:     nxt_rdata = {xst_ff == ST_VALID, 6'h00,
                                        sw_pend_ff};
      default:             nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff <= 8'h00;
    end else begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
    end
  end
  assign reg_rdata = reg_rdata_ff;

  // valid detector: count edges of pin b after enable
  osc_edge_counter u_settle (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clear   (xst_ff != ST_SETTLE),
    .osc_in  (xb_s),
    .limit   (`OSC_SETTLE_EDGES),
    .done    (settle_done)
  );

  // precision ready after start-up edges, restarts when disabled
  osc_edge_counter u_prec (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clear   (!prec_en_ff),
    .osc_in  (prec_s),
    .limit   (`OSC_PREC_START),
    .done    (prec_done)
  );

  always @* begin
    nxt_xst = ST_IDLE;
    case (xst_ff)
      ST_IDLE:   nxt_xst = (ext_en && !is_cmos) ? ST_SETTLE : ST_IDLE;
      ST_SETTLE: nxt_xst = settle_done ? ST_VALID : ST_SETTLE;
      ST_VALID:  nxt_xst = ST_VALID;
      default:   nxt_xst = ST_IDLE;
    endcase
    // any rewrite of the config restarts detection
    if (!ext_en || is_cmos || wr_ext) begin
      nxt_xst = ST_IDLE;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      xst_ff <= ST_IDLE;
    end else begin
      xst_ff <= nxt_xst;
    end
  end

  // divide-by-two toggles on rising edge: equal halves
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_div_ff <= 1'b0;
      xb_prev_ff <= 1'b0;
    end else begin
      xb_prev_ff <= xb_s;
      if (!ext_en) begin
        ext_div_ff <= 1'b0;
      end else if (xb_rise) begin
        ext_div_ff <= ~ext_div_ff;
      end
    end
  end

  // low power divide by 8; precision edge history for the spread ramp
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lp_div_ff      <= 3'h0;
      lp_div_prev_ff <= 1'b0;
      prec_prev_ff   <= 1'b0;
    end else begin
      lp_div_prev_ff <= lp_s;
      prec_prev_ff   <= prec_s;
      if (lp_s && !lp_div_prev_ff) begin
        lp_div_ff <= lp_div_ff + 3'h1;
      end
    end
  end

  // spread: triangle of steps, each half holds fosc/384/2 per ramp
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ss_cnt_ff  <= 9'h000;
      ss_step_ff <= 3'h0;
      ss_down_ff <= 1'b1;
    end else if (!spread_ff || !prec_en_ff) begin
      ss_cnt_ff  <= 9'h000;
      ss_step_ff <= 3'h0;
      ss_down_ff <= 1'b1;
    end else if (prec_s && !prec_prev_ff) begin
      if (ss_cnt_ff == `OSC_SS_STEP_LAST) begin
        ss_cnt_ff <= 9'h000;
        // 6 steps of 0.26 percent stay within 1.6 percent, never above nominal
        if (ss_down_ff) begin
          if (ss_step_ff == `OSC_SS_STEPS) begin
            ss_down_ff <= 1'b0;
            ss_step_ff <= ss_step_ff - 3'h1;
          end else begin
            ss_step_ff <= ss_step_ff + 3'h1;
          end
        end else begin
          if (ss_step_ff == 3'h0) begin
            ss_down_ff <= 1'b1;
            ss_step_ff <= 3'h1;
          end else begin
            ss_step_ff <= ss_step_ff - 3'h1;
          end
        end
      end else begin
        ss_cnt_ff <= ss_cnt_ff + 9'h001;
      end
    end
  end

  // source switch: wait one period of the slower of old and new clocks
  always @* begin
    case (sel_act_ff)
      `OSC_SEL_PREC:   old_clk = prec_s;
      `OSC_SEL_EXT:    old_clk = ext_clk;
      `OSC_SEL_LP_DIV8: old_clk = lp_div8;
      `OSC_SEL_RTC:    old_clk = rtc_s;
      default:         old_clk = lp_s;
    endcase
    case (sel_req_ff)
      `OSC_SEL_PREC:   new_clk = prec_s;
      `OSC_SEL_EXT:    new_clk = ext_clk;
      `OSC_SEL_LP_DIV8: new_clk = lp_div8;
      `OSC_SEL_RTC:    new_clk = rtc_s;
      default:         new_clk = lp_s;
    endcase
  end

  // each pair of rising edges counts one full period
  osc_edge_counter u_old (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clear   (!sw_pend_ff),
    .osc_in  (old_clk),
    .limit   (`OSC_SWITCH_EDGES),
    .done    (old_slow)
  );

  osc_edge_counter u_new (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clear   (!sw_pend_ff),
    .osc_in  (new_clk),
    .limit   (`OSC_SWITCH_EDGES),
    .done    (new_slow)
  );

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sel_act_ff <= `OSC_SEL_RST;
      sw_pend_ff <= 1'b0;
    end else if (sel_req_ff == sel_act_ff) begin
      sw_pend_ff <= 1'b0;
    end else if (!sw_pend_ff) begin
      sw_pend_ff <= 1'b1;
    end else if (old_slow && new_slow) begin
      sel_act_ff <= sel_req_ff;
      sw_pend_ff <= 1'b0;
    end
  end

  assign sysclk_src     = sel_act_ff;
  assign sysclk_undiv   = old_clk;
  assign ext_periph_clk = ext_en ? ext_clk : 1'b0;
  // low power runs while selected or being switched to or away from
  assign lp_osc_en = (sel_act_ff == `OSC_SEL_LP) ||
                     (sel_act_ff == `OSC_SEL_LP_DIV8) ||
                     (sel_req_ff == `OSC_SEL_LP) ||
                     (sel_req_ff == `OSC_SEL_LP_DIV8);
  assign prec_osc_en      = prec_en_ff;
  assign prec_osc_trim    = trim_ff;
  assign prec_osc_ss_step = ss_step_ff;
  assign ext_osc_en          = ext_en;
  assign ext_osc_mode        = mode;
  assign ext_osc_drive_level = ext_cfg_ff[`OSC_EXT_DRV_HI:`OSC_EXT_DRV_LO];
  // pins are never driven digitally here; analog or digital input only
  assign ext_osc_pin_a_out  = 1'b0;
  assign ext_osc_pin_a_oe_b = 1'b1;
  assign ext_osc_pin_b_out  = 1'b0;
  assign ext_osc_pin_b_oe_b = 1'b1;
endmodule // osc_source_ctrl

//--- test/osc_source_props.sv
// assertions on the oscillator source control ports
// assumes binding to osc_source_ctrl, one clk_sys domain
`timescale 1ns/1ps
`include "osc_consts.vh"
module osc_source_props (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       ext_osc_pin_a_out,
  input wire logic       ext_osc_pin_a_oe_b,
  input wire logic       ext_osc_pin_b_out,
  input wire logic       ext_osc_pin_b_oe_b,
  input wire logic       prec_osc_en,
  input wire logic [2:0] prec_osc_ss_step,
  input wire logic       lp_osc_en,
  input wire logic       ext_osc_en,
  input wire logic [1:0] ext_osc_mode,
  input wire logic [2:0] ext_osc_drive_level,
  input wire logic [2:0] sysclk_src
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence cfg_wr;
    reg_wr && reg_addr == `OSC_OFS_EXT_CFG;
  endsequence
  sequence stat_rd;
    reg_rd && reg_addr == `OSC_OFS_STATUS;
  endsequence
  sequence sel_wr;
    reg_wr && reg_addr == `OSC_OFS_SYSCLK_SEL &&
      reg_wdata[2:0] != sysclk_src && reg_wdata[2:0] <= `OSC_SEL_LP;
  endsequence

  chk_lp_when_sel: assert property (
    sysclk_src inside {`OSC_SEL_LP, `OSC_SEL_LP_DIV8} |-> lp_osc_en)
    else $error("low power osc off while selected");
  chk_src_legal: assert property (
    sysclk_src <= `OSC_SEL_LP) else $error("reserved source active");
  chk_ss_bound: assert property (
    prec_osc_ss_step <= `OSC_SS_STEPS) else $error("spread step too deep");
  chk_cmos_valid: assert property (
    stat_rd ##0 ext_osc_mode == `OSC_MODE_CMOS |=> !reg_rdata[7])
    else $error("valid flag set in cmos mode");
  chk_off_valid: assert property (
    stat_rd ##0 !ext_osc_en |=> !reg_rdata[7])
    else $error("valid flag set while disabled");
  chk_cfg_restart: assert property (
    cfg_wr ##2 stat_rd |=> !reg_rdata[7])
    else $error("valid flag kept after config write");
  chk_cfg_fields: assert property (
    cfg_wr |=> ext_osc_en == $past(reg_wdata[7]) &&
      ext_osc_mode == $past(reg_wdata[5:4]) &&
      ext_osc_drive_level == $past(reg_wdata[2:0]))
    else $error("ext config fields not applied");
  chk_prec_en: assert property (
    reg_wr && reg_addr == `OSC_OFS_PREC_CTRL |=>
      prec_osc_en == $past(reg_wdata[7]))
    else $error("precision enable not applied");
  chk_switch_hold: assert property (
    sel_wr |=> $stable(sysclk_src) [*2])
    else $error("source switched without slow clock period");
  chk_pins_free: assert property (
    ext_osc_pin_a_oe_b && ext_osc_pin_b_oe_b &&
      !ext_osc_pin_a_out && !ext_osc_pin_b_out)
    else $error("oscillator pin driven");
endmodule // osc_source_props

//--- test/osc_ext_model.sv
// external crystal, rc, capacitor or cmos clock at the oscillator pins
// assumes run high only while the far side oscillates
`timescale 1ns/1ps
module osc_ext_model (
  input  wire logic       clk_sys,
  input  wire logic       run,
  input  wire logic [2:0] half,
  output logic            pin_a,
  output logic            pin_b = 1'b0
);
  logic [2:0] cnt = 3'h0;

  // a stopped oscillator stands still, it never floats
  always @(posedge clk_sys) begin
    if (!run) begin
      cnt <= 3'h0;
    end else if (cnt >= half - 3'h1) begin
      cnt   <= 3'h0;
      pin_b <= ~pin_b;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
  // crystal sits across both pins; unused pin in cmos mode
  assign pin_a = ~pin_b;
endmodule // osc_ext_model

//--- test/test_osc_source_ctrl.sv
// self-checking bench for the oscillator source control block
// assumes osc_ext_model at the pins, osc_source_props bound below
`timescale 1ns/1ps
`include "osc_consts.vh"
module test_osc_source_ctrl;
  logic       clk_sys, rst_b, reg_wr, reg_rd, ext_on;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, d;
  logic [6:0] t;
  logic [2:0] half;
  logic [4:0] tap = 5'h0;
  wire        pin_a, pin_b, prec_osc_en, lp_osc_en, ext_osc_en, run;
  wire        sysclk_undiv, ext_periph_clk;
  wire  [7:0] reg_rdata;
  wire  [6:0] prec_osc_trim;
  wire  [2:0] ss_step, sysclk_src;
  wire  [1:0] ext_osc_mode;
  int         error_cnt, num_checks, m_sel;

  osc_source_ctrl osc_source_ctrl_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .prec_osc_clk(tap[1]), .lp_osc_clk(tap[2]),
    .rtc_osc_clk(tap[4]), .ext_osc_pin_a_in(pin_a),
    .ext_osc_pin_b_in(pin_b), .ext_osc_pin_a_out(), .ext_osc_pin_a_oe_b(),
    .ext_osc_pin_b_out(), .ext_osc_pin_b_oe_b(),
    .prec_osc_en(prec_osc_en), .prec_osc_trim(prec_osc_trim),
    .prec_osc_ss_step(ss_step), .lp_osc_en(lp_osc_en),
    .ext_osc_en(ext_osc_en), .ext_osc_mode(ext_osc_mode),
    .ext_osc_drive_level(), .sysclk_src(sysclk_src),
    .ext_periph_clk(ext_periph_clk), .sysclk_undiv(sysclk_undiv));
  assign run = ext_on && (ext_osc_en || ext_osc_mode == `OSC_MODE_CMOS);
  osc_ext_model osc_ext_model_inst (
    .clk_sys(clk_sys), .run(run), .half(half), .pin_a(pin_a), .pin_b(pin_b));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) tap <= tap + 5'h1;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(v, exp);
  endtask
  task automatic poll(input logic [3:0] a, input int b, input logic v);
    logic [7:0] r;
    for (int n = 0; n < 1500; n++) begin
      rd(a, r);
      if (r[b] === v) break;
    end
    check({7'h0, r[b]}, {7'h0, v});
  endtask
  // rising edges of a clock view over 64 system clocks
  task automatic rises(input int w, input logic [7:0] exp);
    logic [7:0] n;
    logic       p, s;
    n = 8'h00;
    #1 p = w ? ext_periph_clk : sysclk_undiv;
    repeat (64) begin
      @(posedge clk_sys);
      #1 s = w ? ext_periph_clk : sysclk_undiv;
      if (s && !p) n++;
      p = s;
    end
    check(n, exp);
    @(posedge clk_sys);
  endtask
  // reserved codes leave the model source untouched
  task automatic sel(input int c);
    wr(`OSC_OFS_SYSCLK_SEL, 8'(c));
    if (c <= 4) m_sel = c;
    poll(`OSC_OFS_STATUS, 0, 1'b0);
    rc(`OSC_OFS_SYSCLK_SEL, 8'(m_sel));
    check({7'h0, lp_osc_en}, {7'h0, m_sel == 2 || m_sel == 4});
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end

  initial begin
    {rst_b, reg_wr, reg_rd, ext_on, reg_addr, reg_wdata} = '0;
    half  = 3'h2;
    m_sel = 4;
    void'($urandom(93));
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rc(`OSC_OFS_SYSCLK_SEL, 8'h04);
    rc(`OSC_OFS_PREC_TRIM, 8'h40);
    rc(`OSC_OFS_STATUS, 8'h00);
    wr(4'hF, 8'hFF);
    rc(4'hF, 8'h00);
    for (int c = 5; c < 8; c++) sel(c);
    sel(2);
    sel(3);
    sel(4);
    wr(`OSC_OFS_PREC_CTRL, 8'h80);
    poll(`OSC_OFS_PREC_CTRL, 6, 1'b1);
    sel(0);
    t = 7'($urandom_range(127, 0));
    wr(`OSC_OFS_PREC_TRIM, {1'b1, t});
    check({1'b0, prec_osc_trim}, {1'b0, t});
    repeat (600) @(posedge clk_sys);
    check({7'h0, ss_step != 3'h0}, 8'h01);
    wr(`OSC_OFS_PREC_TRIM, {1'b0, t});
    repeat (600) @(posedge clk_sys);
    check({5'h0, ss_step}, 8'h00);
    ext_on <= 1'b1;
    // crystal (with halving), rc and capacitor starts
    for (int m = 1; m < 4; m++) begin
      half <= 3'($urandom_range(4, 2));
      d = {1'b1, 1'(m == 1), 2'(m), 1'b0, 3'($urandom_range(7, 0))};
      wr(`OSC_OFS_EXT_CFG, d);
      rc(`OSC_OFS_STATUS, 8'h00);
      // settle wait far below the real crystal time to keep runs short
      repeat (300) @(posedge clk_sys);
      poll(`OSC_OFS_STATUS, 7, 1'b1);
      rc(`OSC_OFS_EXT_CFG, d);
      sel(1);
      sel(0);
    end
    half <= 3'h2;
    wr(`OSC_OFS_EXT_CFG, 8'h87);
    repeat (1500) @(posedge clk_sys);
    rc(`OSC_OFS_STATUS, 8'h00);
    rises(1, 8'h10);
    sel(1);
    sel(4);
    rises(0, 8'h08);
    wr(`OSC_OFS_PREC_CTRL, 8'h00);
    check({7'h0, prec_osc_en}, 8'h00);
    wr(`OSC_OFS_EXT_CFG, 8'h17);
    wr(`OSC_OFS_STATUS, 8'hFF);
    rc(`OSC_OFS_STATUS, 8'h00);
    rises(1, 8'h00);
    wr(`OSC_OFS_PREC_CTRL, 8'h80);
    poll(`OSC_OFS_PREC_CTRL, 6, 1'b1);
    sel(0);
    rises(0, 8'h10);
    // second reset in mid-run must bring back the low power source
    rst_b <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    m_sel = 4;
    rc(`OSC_OFS_SYSCLK_SEL, 8'h04);
    check({7'h0, lp_osc_en}, 8'h01);
    give_verdict();
  end
endmodule // test_osc_source_ctrl

bind osc_source_ctrl osc_source_props osc_source_props_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ext_osc_pin_a_oe_b(ext_osc_pin_a_oe_b),
  .ext_osc_pin_a_out(ext_osc_pin_a_out),
  .ext_osc_pin_b_out(ext_osc_pin_b_out),
  .ext_osc_pin_b_oe_b(ext_osc_pin_b_oe_b), .prec_osc_en(prec_osc_en),
  .prec_osc_ss_step(prec_osc_ss_step), .lp_osc_en(lp_osc_en),
  .ext_osc_en(ext_osc_en), .ext_osc_mode(ext_osc_mode),
  .ext_osc_drive_level(ext_osc_drive_level), .sysclk_src(sysclk_src));
